// >>> core/pmc_power_mode_controller.v
// Power mode controller: sequences normal, idle, suspend, stop and shutdown modes.
// Assumes a classic Wishbone master, synchronous inputs, and wake/reset sources from the chip.
// ****************************************************************
// ****************************************************************
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`include "pmc_defines.vh"
module pmc_power_mode_controller #(
    parameter N_PERIPH = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire irq_pending_i,
    input wire usb_bus_activity_i,
    input wire other_reset_i,
    input wire reset_pin_n_i,
    input wire por_i,
    input wire [N_PERIPH-1:0] periph_in_use_i,
    output reg core_clk_en_o,
    output reg periph_clk_en_o,
    output wire [N_PERIPH-1:0] periph_gate_o,
    output reg power_nets_on_o,
    output reg pin_retain_o,
    output reg reg5v_on_o,
    output reg [1:0] system_clock_sel_o,
    output reg [1:0] osc_pre_div_o,
    output reg [2:0] osc_post_div_o,
    output reg [4:0] mode_o,
    output reg irq_o
);
    // ****************************************************************
    // Mode state
    // ****************************************************************
    localparam [4:0] S_NORMAL = `PMC_MODE_NORMAL;
    localparam [4:0] S_IDLE = `PMC_MODE_IDLE;
    localparam [4:0] S_SUSPEND = `PMC_MODE_SUSPEND;
    localparam [4:0] S_STOP = `PMC_MODE_STOP;
    localparam [4:0] S_SHUTDOWN = `PMC_MODE_SHUTDOWN;

    reg [4:0] state_q;
    reg [4:0] state_d;
    reg idle_req_q;
    reg stop_req_q;
    reg suspend_req_q;
    reg shutdown_sel_q;
    reg reg5v_en_q;
    reg [N_PERIPH-1:0] periph_en_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_mask_q;
    reg [2:0] ev;
    reg idle_wake;
    reg susp_wake;

    wire bus_req = cyc_i & stb_i & ~ack_o;
    wire wr = bus_req & we_i & sel_i[0];
    // A pin event or power-on reset is the only way out of shutdown.
    wire hard_reset = ~reset_pin_n_i | por_i;
    wire any_reset = hard_reset | other_reset_i;

    always @* begin
        state_d = state_q;
        idle_wake = 1'b0;
        susp_wake = 1'b0;
        ev = 3'h0;
        case (state_q)
            S_NORMAL: begin
                if (stop_req_q) begin
                    state_d = shutdown_sel_q ? S_SHUTDOWN : S_STOP;
                end else if (suspend_req_q && system_clock_sel_o == `PMC_CLK_SEL_HFOSC) begin
                    state_d = S_SUSPEND;
                end else if (idle_req_q) begin
                    state_d = S_IDLE;
                end
            end
            S_IDLE: begin
                if (irq_pending_i) begin
                    state_d = S_NORMAL;
                    idle_wake = 1'b1;
                    ev[`PMC_EV_IDLE_WAKE] = 1'b1;
                end
            end
            S_SUSPEND: begin
                if (usb_bus_activity_i) begin
                    state_d = S_NORMAL;
                    susp_wake = 1'b1;
                    ev[`PMC_EV_SUSP_WAKE] = 1'b1;
                end
            end
            S_STOP: begin
                if (any_reset) begin
                    state_d = S_NORMAL;
                    ev[`PMC_EV_STOP_EXIT] = 1'b1;
                end
            end
            S_SHUTDOWN: begin
                if (hard_reset) begin
                    state_d = S_NORMAL;
                    ev[`PMC_EV_STOP_EXIT] = 1'b1;
                end
            end
            default: begin
                state_d = S_NORMAL;
            end
        endcase
    end

    // ****************************************************************
    // Register decode
    // ****************************************************************
    // Only byte lane zero is decoded, so a write with sel_i[0] low is ignored but still answered.
    wire wr_pwr_ctrl = wr && (adr_i == `PMC_ADR_PWR_CTRL);
    wire wr_hf_osc = wr && (adr_i == `PMC_ADR_HF_OSC);
    wire wr_reg_ctrl = wr && (adr_i == `PMC_ADR_REG_CTRL);
    wire wr_clk_cfg = wr && (adr_i == `PMC_ADR_CLK_CFG);
    wire wr_periph_en = wr && (adr_i == `PMC_ADR_PERIPH_EN);
    wire wr_irq_stat = wr && (adr_i == `PMC_ADR_IRQ_STAT);
    wire wr_irq_mask = wr && (adr_i == `PMC_ADR_IRQ_MASK);
    wire rd_req = bus_req & ~we_i;

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    // Every access is answered on the first edge with ce_i high after it is taken, so a master waits longer while ce_i is low.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else if (ce_i) begin
            ack_o <= bus_req;
        end
    end

    // ****************************************************************
    // Control register next values
    // ****************************************************************
    reg idle_req_d;
    reg stop_req_d;
    reg suspend_req_d;
    reg shutdown_sel_d;
    reg reg5v_en_d;
    reg [N_PERIPH-1:0] periph_en_d;
    reg [2:0] irq_stat_d;
    reg [2:0] irq_mask_d;

    always @* begin
        idle_req_d = idle_req_q;
        stop_req_d = stop_req_q;
        suspend_req_d = suspend_req_q;
        shutdown_sel_d = shutdown_sel_q;
        reg5v_en_d = reg5v_en_q;
        periph_en_d = periph_en_q;
        irq_mask_d = irq_mask_q;
        if (wr_pwr_ctrl) begin
            idle_req_d = dat_i[`PMC_BIT_IDLE];
            stop_req_d = dat_i[`PMC_BIT_STOP];
        end
        if (wr_hf_osc) begin
            suspend_req_d = dat_i[`PMC_BIT_SUSPEND];
        end
        if (wr_reg_ctrl) begin
            shutdown_sel_d = dat_i[`PMC_BIT_SHUTDOWN_SEL];
            reg5v_en_d = dat_i[`PMC_BIT_REG5V_EN];
        end
        if (wr_periph_en) begin
            periph_en_d = dat_i[N_PERIPH-1:0];
        end
        if (wr_irq_mask) begin
            irq_mask_d = dat_i[2:0];
        end
        // A wake clears its request after any firmware write, so the wake is never undone.
        if (idle_wake) begin
            idle_req_d = 1'b0;
        end
        if (susp_wake) begin
            suspend_req_d = 1'b0;
        end
        // The stop request is used up on entry, so the exit does not fall straight back into stop.
        if (state_q == S_NORMAL && state_d != S_NORMAL && stop_req_q) begin
            stop_req_d = 1'b0;
        end
    end

    // ****************************************************************
    // Interrupt status next value
    // ****************************************************************
    // A wake event that meets a write-one-to-clear in the same cycle keeps its bit set.
    always @* begin
        irq_stat_d = irq_stat_q & ~(wr_irq_stat ? dat_i[2:0] : 3'h0);
        irq_stat_d = irq_stat_d | ev;
    end

    // ****************************************************************
    // State and control registers
    // ****************************************************************
    // All state holds while the clock enable is low.
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_NORMAL;
            idle_req_q <= 1'b0;
            stop_req_q <= 1'b0;
            suspend_req_q <= 1'b0;
            shutdown_sel_q <= 1'b0;
            reg5v_en_q <= 1'b1;
            periph_en_q <= {N_PERIPH{1'b0}};
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
        end else if (ce_i) begin
            state_q <= state_d;
            idle_req_q <= idle_req_d;
            stop_req_q <= stop_req_d;
            suspend_req_q <= suspend_req_d;
            shutdown_sel_q <= shutdown_sel_d;
            reg5v_en_q <= reg5v_en_d;
            periph_en_q <= periph_en_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // ****************************************************************
    // Clock configuration
    // ****************************************************************
    // The selector and dividers are plain outputs; the oscillator itself lives outside this block.
    always @(posedge clk_i) begin
        if (rst_i) begin
            system_clock_sel_o <= `PMC_RST_CLK_SEL;
            osc_pre_div_o <= `PMC_RST_PRE_DIV;
            osc_post_div_o <= `PMC_RST_POST_DIV;
        end else if (ce_i && wr_clk_cfg) begin
            system_clock_sel_o <= dat_i[1:0];
            osc_pre_div_o <= dat_i[3:2];
            osc_post_div_o <= dat_i[6:4];
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Unmapped indices read as zero and ignore writes, but are still answered.
    reg [31:0] rd_data_d;

    always @* begin
        case (adr_i)
            `PMC_ADR_PWR_CTRL: rd_data_d = {30'h0, stop_req_q, idle_req_q};
            `PMC_ADR_HF_OSC: rd_data_d = {31'h0, suspend_req_q};
            `PMC_ADR_REG_CTRL: rd_data_d = {30'h0, reg5v_en_q, shutdown_sel_q};
            `PMC_ADR_CLK_CFG: rd_data_d = {25'h0, osc_post_div_o, osc_pre_div_o, system_clock_sel_o};
            `PMC_ADR_PERIPH_EN: rd_data_d = {{(32-N_PERIPH){1'b0}}, periph_en_q};
            `PMC_ADR_STATUS: rd_data_d = {27'h0, state_q};
            `PMC_ADR_IRQ_STAT: rd_data_d = {29'h0, irq_stat_q};
            `PMC_ADR_IRQ_MASK: rd_data_d = {29'h0, irq_mask_q};
            default: rd_data_d = 32'h0;
        endcase
    end

    // The read word is held until the next read, so a slow master still finds it.
    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (ce_i && rd_req) begin
            dat_o <= rd_data_d;
        end
    end

    // ****************************************************************
    // Clock enables
    // ****************************************************************
    // Enables follow the next state, so they change on the same edge as the mode register.
    always @(posedge clk_i) begin
        if (rst_i) begin
            core_clk_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
        end else if (ce_i) begin
            core_clk_en_o <= (state_d == S_NORMAL);
            periph_clk_en_o <= (state_d == S_NORMAL) || (state_d == S_IDLE);
        end
    end

    // ****************************************************************
    // Power nets and pin retention
    // ****************************************************************
    // The regulator ignores the mode, so a 5V supply that was enabled stays up through shutdown.
    always @(posedge clk_i) begin
        if (rst_i) begin
            power_nets_on_o <= 1'b1;
            pin_retain_o <= 1'b0;
            reg5v_on_o <= 1'b1;
        end else if (ce_i) begin
            power_nets_on_o <= !(state_d == S_STOP || state_d == S_SHUTDOWN);
            pin_retain_o <= (state_d == S_STOP || state_d == S_SHUTDOWN);
            reg5v_on_o <= reg5v_en_q;
        end
    end

    // ****************************************************************
    // Mode and interrupt outputs
    // ****************************************************************
    // The interrupt line is registered, so it follows a status or mask change one cycle later.
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_o <= S_NORMAL;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            mode_o <= state_d;
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ****************************************************************
    // Peripheral clock gates
    // ****************************************************************
    // A gate drops its enable when its peripheral is unused or the mode stops peripheral clocks.
    genvar g;
    generate
        for (g = 0; g < N_PERIPH; g = g + 1) begin : g_gate
            pmc_clk_gate u_gate (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .run_i(state_d == S_NORMAL || state_d == S_IDLE),
                .in_use_i(periph_en_q[g] & periph_in_use_i[g]),
                .gate_o(periph_gate_o[g])
            );
        end
    endgenerate
endmodule // pmc_power_mode_controller

// >>> include/pmc_defines.vh
// Constants for the power mode controller: register offsets, bit positions, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH
`define PMC_ADR_PWR_CTRL 4'h0
`define PMC_ADR_HF_OSC 4'h1
`define PMC_ADR_REG_CTRL 4'h2
`define PMC_ADR_CLK_CFG 4'h3
`define PMC_ADR_PERIPH_EN 4'h4
`define PMC_ADR_STATUS 4'h5
`define PMC_ADR_IRQ_STAT 4'h6
`define PMC_ADR_IRQ_MASK 4'h7
`define PMC_BIT_IDLE 0
`define PMC_BIT_STOP 1
`define PMC_BIT_SUSPEND 0
`define PMC_BIT_SHUTDOWN_SEL 0
`define PMC_BIT_REG5V_EN 1
`define PMC_CLK_SEL_HFOSC 2'h0
`define PMC_RST_CLK_SEL 2'h0
`define PMC_RST_PRE_DIV 2'h2
`define PMC_RST_POST_DIV 3'h3
`define PMC_RST_REG_CTRL 2'h2
`define PMC_MODE_NORMAL 5'h01
`define PMC_MODE_IDLE 5'h02
`define PMC_MODE_SUSPEND 5'h04
`define PMC_MODE_STOP 5'h08
`define PMC_MODE_SHUTDOWN 5'h10
`define PMC_EV_IDLE_WAKE 0
`define PMC_EV_SUSP_WAKE 1
`define PMC_EV_STOP_EXIT 2
`endif

// >>> core/pmc_clk_gate.v
// Clock-enable gate for one consumer: holds an enable flop that follows a request.
// Assumes the consumer treats the enable as a synchronous clock qualifier.
module pmc_clk_gate (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire run_i,
    input wire in_use_i,
    output reg gate_o
);
    always @(posedge clk_i) begin
        if (rst_i) begin
            gate_o <= 1'b0;
        end else if (ce_i) begin
            gate_o <= run_i & in_use_i;
        end
    end
endmodule // pmc_clk_gate

// >>> tb/pmc_power_mode_controller_chk.sv
// Checker for the power mode controller: port-level assertions only.
// Assumes a bind into pmc_power_mode_controller and the single clock clk_i.
module pmc_power_mode_controller_chk #(
    parameter N_PERIPH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic irq_pending_i,
    input wire logic usb_bus_activity_i,
    input wire logic reset_pin_n_i,
    input wire logic por_i,
    input wire logic [N_PERIPH-1:0] periph_in_use_i,
    input wire logic [N_PERIPH-1:0] periph_gate_o,
    input wire logic core_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic power_nets_on_o,
    input wire logic pin_retain_o,
    input wire logic [1:0] system_clock_sel_o,
    input wire logic [1:0] osc_pre_div_o,
    input wire logic [2:0] osc_post_div_o,
    input wire logic [4:0] mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o) else $error("ack missing");
    a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o) else $error("ack held");
    a_reset_clock: assert property ($past(rst_i) |-> system_clock_sel_o == 2'h0 && osc_pre_div_o == 2'h2
        && osc_post_div_o == 3'h3) else $error("reset clock setting wrong");
    a_normal_run: assert property (mode_o == 5'h01 |-> core_clk_en_o && periph_clk_en_o) else $error("normal halted");
    a_idle_halt: assert property (mode_o == 5'h02 |-> !core_clk_en_o && periph_clk_en_o) else $error("idle clocks");
    a_susp_halt: assert property (mode_o == 5'h04 |-> !core_clk_en_o && !periph_clk_en_o) else $error("suspend clocks");
    a_stop_power: assert property (mode_o[3] || mode_o[4] |-> !power_nets_on_o && pin_retain_o)
        else $error("stop power wrong");
    a_gate_unused: assert property ($past(ce_i) |-> (periph_gate_o & ~$past(periph_in_use_i)) == '0)
        else $error("unused clock on");
    a_idle_wake: assert property (mode_o == 5'h02 && irq_pending_i && ce_i |-> ##[1:3] mode_o == 5'h01)
        else $error("idle no wake");
    a_susp_wake: assert property (mode_o == 5'h04 && usb_bus_activity_i && ce_i |-> ##[1:3] mode_o == 5'h01)
        else $error("suspend no wake");
    a_shut_hold: assert property (mode_o == 5'h10 && reset_pin_n_i && !por_i && ce_i |=> mode_o == 5'h10)
        else $error("shutdown left");
endmodule // pmc_power_mode_controller_chk
bind pmc_power_mode_controller pmc_power_mode_controller_chk #(.N_PERIPH(N_PERIPH)) u_chk (.*);

// >>> tb/test_pmc_power_mode_controller.sv
// Self-checking bench for the power mode controller over classic Wishbone.
// Assumes one 25 MHz clock; ce_i is held high throughout.
module test_pmc_power_mode_controller;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, irq_pending_i = 0;
    logic usb_bus_activity_i = 0, other_reset_i = 0, reset_pin_n_i = 1, por_i = 0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, rd;
    logic [7:0] periph_in_use_i = 8'h00, en;
    wire [31:0] dat_o;
    wire [7:0] periph_gate_o;
    wire [4:0] mode_o;
    wire [2:0] osc_post_div_o;
    wire [1:0] system_clock_sel_o, osc_pre_div_o;
    wire ack_o, core_clk_en_o, periph_clk_en_o, power_nets_on_o, pin_retain_o, reg5v_on_o, irq_o;
    int err_count = 0, num_checks = 0, cyc_n = 0, i;
    integer seed = 32'h7289;
    wire [8:0] outs = {mode_o, core_clk_en_o, periph_clk_en_o, power_nets_on_o, pin_retain_o};
    pmc_power_mode_controller #(.N_PERIPH(8)) uut (.*);
    initial forever #20 clk_i = ~clk_i;
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Mode, core clock, peripheral clock, power nets and pin retention expected in a given mode.
    function automatic logic [8:0] exp_outs(input logic [4:0] m);
        return {m, m == 5'h01, m == 5'h01 || m == 5'h02, !(m[3] || m[4]), m[3] || m[4]};
    endfunction
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // The request stands until ack is sampled high, so slow answers are safe.
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 0; stb_i <= 0;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n > 4000) begin
            err_count++;
            wrap_up;
        end
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        wt(6);
        rst_i <= 0;
        wt(2);
        chk("clock cfg", {system_clock_sel_o, osc_pre_div_o, osc_post_div_o}, {2'h0, 2'h2, 3'h3});
        chk("normal", outs, exp_outs(5'h01));
        for (i = 0; i < 5; i++) begin
            en = (i == 0) ? 8'hFF : 8'($random(seed));
            periph_in_use_i <= (i == 4) ? 8'h00 : 8'($random(seed));
            wb(1, 4'h4, {24'h0, en});
            wt(3);
            chk("gates", periph_gate_o, en & periph_in_use_i);
        end
        wb(0, 4'h8, 32'h0);
        chk("unmapped", rd, 32'h0);
        $display("gate test done");
        wb(1, 4'h0, 32'h1);
        wt(4);
        chk("idle", outs, exp_outs(5'h02));
        irq_pending_i <= 1;
        wt(4);
        irq_pending_i <= 0;
        chk("idle wake", {mode_o, irq_o}, {5'h01, 1'b0});
        wb(0, 4'h0, 32'h0);
        chk("idle bit", rd[0], 1'b0);
        wb(1, 4'h7, 32'h7);
        wt(2);
        chk("irq", irq_o, 1'b1);
        wb(1, 4'h6, 32'h7);
        wt(2);
        chk("irq clear", irq_o, 1'b0);
        $display("idle test done");
        wb(1, 4'h3, 32'h39);
        wb(1, 4'h1, 32'h1);
        wt(4);
        chk("suspend wait", mode_o, 5'h01);
        wb(1, 4'h3, 32'h38);
        wt(4);
        chk("suspend", outs, exp_outs(5'h04));
        usb_bus_activity_i <= 1;
        wt(4);
        usb_bus_activity_i <= 0;
        chk("suspend wake", outs, exp_outs(5'h01));
        wb(0, 4'h1, 32'h0);
        chk("suspend bit", rd[0], 1'b0);
        $display("suspend test done");
        for (i = 0; i < 3; i++) begin
            wb(1, 4'h2, {30'h0, i != 2, i > 0});
            wb(1, 4'h0, 32'h2);
            wt(4);
            chk("stop", {mode_o, power_nets_on_o, pin_retain_o, reg5v_on_o}, {(i > 0) ? 5'h10 : 5'h08, 2'b01, i != 2});
            other_reset_i <= 1;
            wt(2);
            other_reset_i <= 0;
            wt(3);
            if (i > 0) chk("shutdown hold", mode_o, 5'h10);
            reset_pin_n_i <= (i != 1);
            por_i <= (i == 2);
            wt(2);
            reset_pin_n_i <= 1;
            por_i <= 0;
            wt(3);
            chk("exit", mode_o, 5'h01);
        end
        $display("stop test done");
        wrap_up;
    end
endmodule // test_pmc_power_mode_controller
